/* File: src/tsee_slave.sv */
// Two-wire slave front end for sensor registers and 256-byte EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "tsee_consts.svh"
module tsee_slave #(
  parameter int unsigned TOUT_CYC = `TOUT_CYC,
  parameter int unsigned WR_CYC = `WR_CYC
) (
  // System clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address straps
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  // Sensor register side
  input wire logic [15:0] ts_rd_data,
  output logic [7:0] ts_ptr,
  output logic [15:0] ts_wr_data,
  output logic ts_wr_valid,
  // Modes and status
  output logic conv_mode,
  output logic ee_standby,
  output logic ee_busy,
  output logic [1:0] write_protect_flags
);
  import tsee_pkg::*;

  core_t c, n;
  link_if lk ();
  logic [5:0] sync_out;
  logic scl_s;
  logic sda_s;
  logic tog_s;
  logic [2:0] strap_s;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic addr_done;
  logic match;
  logic [7:0] tx_pick;
  logic [`TOUT_W-1:0] tout_last;
  logic [`WR_W-1:0] wr_last;

  // Link-side shifter runs on SCL itself
  scl_shifter u_link (
    .scl_clk(scl_i),
    .rst(rst),
    .sda_i(sda_i),
    .lk(lk.link)
  );

  // Pins and the rise toggle cross into the system clock
  bit_sync #(.W(6)) u_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .d_in({scl_i, sda_i, lk.rx_tog, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}),
    .q_out(sync_out)
  );

  assign {scl_s, sda_s, tog_s, strap_s} = sync_out;
  assign tout_last = TOUT_CYC[`TOUT_W-1:0] - 1'b1;
  assign wr_last = WR_CYC[`WR_W-1:0] - 1'b1;

  // Bus conditions seen only with SCL steadily high
  assign start_ev = scl_s & c.scl_prev & c.sda_prev & ~sda_s;
  assign stop_ev = scl_s & c.scl_prev & ~c.sda_prev & sda_s;
  assign rise_ev = tog_s ^ c.tog_prev;
  assign addr_done = (c.ph == ADDR_S) && rise_ev && (c.cnt == `BIT_LAST);

  // Preamble, straps and busy decide whether we answer
  assign match = ((lk.rx_byte[7:4] == `PRE_TS) || (lk.rx_byte[7:4] == `PRE_EE))
    && (lk.rx_byte[3:1] == strap_s)
    && !c.busy;

  // Byte to send from the selected pointer
  always_comb begin
    if (c.sel_presence_eeprom) begin
      tx_pick = c.mem[c.ee_addr];
    end else if (c.tx_lo) begin
      tx_pick = ts_rd_data[7:0];
    end else begin
      tx_pick = ts_rd_data[15:8];
    end
  end

  always_comb begin
    n = c;
    n.scl_prev = scl_s;
    n.sda_prev = sda_s;
    n.tog_prev = tog_s;
    n.ts_wr_valid = 1'b0;
    n.powered = 1'b1;

    // Nonvolatile programming cycle; page lands at its end
    if (c.busy) begin
      if (c.wr_cnt == wr_last) begin
        n.busy = 1'b0;
        n.mask = '0;
        for (int i = 0; i < `PAGE_BYTES; i++) begin
          if (c.mask[i]) begin
            n.mem[{c.prog_page, 4'(i)}] = c.page_buf[i];
          end
        end
      end else begin
        n.wr_cnt = c.wr_cnt + 1'b1;
      end
    end

    // SCL held low too long inside a transaction
    if ((c.ph != IDLE_S) && !scl_s) begin
      if (c.tout_cnt == tout_last) begin
        n.ph = IDLE_S;
        n.drive_req = 1'b0;
        n.tout_cnt = '0;
        if (!c.busy) begin
          n.mask = '0;
        end
      end else begin
        n.tout_cnt = c.tout_cnt + 1'b1;
      end
    end else begin
      n.tout_cnt = '0;
    end

    if (start_ev) begin
      // Also serves as repeated START for selective reads
      n.ph = ADDR_S;
      n.cnt = `CNT_ZERO;
      n.nbyte = `NB_PTR;
      n.drive_req = 1'b0;
      n.tout_cnt = '0;
    end else if (stop_ev) begin
      if (c.ph != IDLE_S) begin
        if ((c.mask != '0) && !c.busy) begin
          n.busy = 1'b1;
          n.wr_cnt = '0;
          n.prog_page = c.ee_addr[7:4];
        end
        if (!c.sel_presence_eeprom && !c.rd && (c.nbyte == `NB_MAX)) begin
          n.ts_wr_valid = 1'b1;
        end
      end
      n.ph = IDLE_S;
      n.drive_req = 1'b0;
    end else if (rise_ev) begin
      n.cnt = (c.cnt == `BIT_ACK) ? `CNT_ZERO : c.cnt + 1'b1;
      unique case (c.ph)
        IDLE_S, IGNORE_S: begin
          n.cnt = c.cnt;
        end
        ADDR_S: begin
          if (c.cnt == `BIT_LAST) begin
            if (match) begin
              n.drive_req = 1'b1;
              n.ph = ACKA_S;
              n.sel_presence_eeprom = (lk.rx_byte[7:4] == `PRE_EE);
              n.rd = lk.rx_byte[0];
              n.tx_lo = 1'b0;
            end else begin
              n.drive_req = 1'b0;
              n.ph = IGNORE_S;
            end
          end
        end
        ACKA_S: begin
          if (c.rd) begin
            n.tx = tx_pick;
            n.drive_req = ~tx_pick[7];
            n.tx_lo = ~c.tx_lo;
            n.ph = TX_S;
          end else begin
            n.drive_req = 1'b0;
            n.ph = RX_S;
          end
        end
        RX_S: begin
          if (c.cnt == `BIT_LAST) begin
            n.drive_req = 1'b1;
            n.ph = ACKR_S;
            if (c.nbyte != `NB_MAX) begin
              n.nbyte = c.nbyte + 1'b1;
            end
            if (c.nbyte == `NB_PTR) begin
              // Pointer only; a repeated START turns this into a read
              if (c.sel_presence_eeprom) begin
                n.ee_addr = lk.rx_byte;
              end else begin
                n.ts_ptr = lk.rx_byte;
              end
            end else if (c.sel_presence_eeprom) begin
              n.page_buf[c.ee_addr[3:0]] = lk.rx_byte;
              n.mask[c.ee_addr[3:0]] = 1'b1;
              n.ee_addr = {c.ee_addr[7:4], c.ee_addr[3:0] + 1'b1};
            end else if (c.nbyte == `NB_D0) begin
              n.ts_wdata[15:8] = lk.rx_byte;
            end else if (c.nbyte == `NB_D1) begin
              n.ts_wdata[7:0] = lk.rx_byte;
            end
          end
        end
        ACKR_S: begin
          n.drive_req = 1'b0;
          n.ph = RX_S;
        end
        TX_S: begin
          if (c.cnt == `BIT_LAST) begin
            n.drive_req = 1'b0;
            n.ph = TXACK_S;
            if (c.sel_presence_eeprom) begin
              n.ee_addr = c.ee_addr + 1'b1;
            end
          end else begin
            n.tx = {c.tx[6:0], 1'b0};
            n.drive_req = ~c.tx[6];
          end
        end
        TXACK_S: begin
          if (!lk.rx_byte[0]) begin
            n.tx = tx_pick;
            n.drive_req = ~tx_pick[7];
            n.tx_lo = ~c.tx_lo;
            n.ph = TX_S;
          end else begin
            n.drive_req = 1'b0;
            n.ph = IGNORE_S;
          end
        end
      endcase
    end
  end

  // Erased array and cleared pointers after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      c <= '0;
      c.ts_ptr <= `PTR_RESET;
      c.ee_addr <= `PTR_RESET;
      c.wp <= `WP_RESET;
      c.mem <= {`EE_BYTES{`ERASED}};
    end else if (ce) begin
      c <= n;
    end
  end

  assign lk.drive_req = c.drive_req;
  // Gate the SCL-side flop so STOP or timeout frees SDA at once
  assign sda_oe = lk.drive_q && (c.ph != IDLE_S) && (c.ph != IGNORE_S);
  assign sda_o = 1'b0;
  assign ts_ptr = c.ts_ptr;
  assign ts_wr_data = c.ts_wdata;
  assign ts_wr_valid = c.ts_wr_valid;
  assign conv_mode = c.powered;
  assign ee_standby = c.powered & ~c.busy;
  assign ee_busy = c.busy;
  assign write_protect_flags = c.wp;

  // Checks kept beside the logic
  AST_ADDR_ACK: assert property (@(posedge clock) disable iff (rst)
    (ce && addr_done && match) |=> (c.ph == ACKA_S) && c.drive_req)
    else $error("matching address not acknowledged");

  AST_ADDR_MISS: assert property (@(posedge clock) disable iff (rst)
    (ce && addr_done && !match && !start_ev && !stop_ev) |=> (c.ph == IGNORE_S) && !c.drive_req)
    else $error("mismatched address not ignored");

  AST_START: assert property (@(posedge clock) disable iff (rst)
    (ce && start_ev) |=> (c.ph == ADDR_S) && (c.cnt == `CNT_ZERO) && !c.drive_req)
    else $error("START not taken");

  AST_STOP: assert property (@(posedge clock) disable iff (rst)
    (ce && stop_ev && !start_ev) |=> (c.ph == IDLE_S) && !sda_oe)
    else $error("STOP did not end transaction");

  AST_BUSY_NACK: assert property (@(posedge clock) disable iff (rst)
    (ce && addr_done && c.busy) |=> !c.drive_req)
    else $error("address acknowledged while programming");

  AST_PAGE_WRAP: assert property (@(posedge clock) disable iff (rst)
    (ce && !start_ev && !stop_ev && rise_ev && (c.ph == RX_S) && (c.cnt == `BIT_LAST)
      && c.sel_presence_eeprom && (c.nbyte != `NB_PTR))
    |=> (c.ee_addr[7:4] == $past(c.ee_addr[7:4])) && (c.ee_addr[3:0] == $past(c.ee_addr[3:0]) + 4'h1))
    else $error("page address did not wrap in page");

  AST_READ_INC: assert property (@(posedge clock) disable iff (rst)
    (ce && !start_ev && !stop_ev && rise_ev && (c.ph == TX_S) && (c.cnt == `BIT_LAST)
      && c.sel_presence_eeprom)
    |=> (c.ee_addr == $past(c.ee_addr) + 8'h01) ##0 (c.ph == TXACK_S))
    else $error("read address not incremented");

  AST_MASTER_NACK: assert property (@(posedge clock) disable iff (rst)
    (ce && !start_ev && !stop_ev && rise_ev && (c.ph == TXACK_S) && lk.rx_byte[0])
    |=> (c.ph == IGNORE_S) && !c.drive_req)
    else $error("drive kept after master NACK");

  AST_PROG_START: assert property (@(posedge clock) disable iff (rst)
    (ce && stop_ev && !start_ev && (c.ph != IDLE_S) && (c.mask != '0) && !c.busy)
    |=> c.busy && (c.wr_cnt == '0) && !ee_standby)
    else $error("programming did not start at STOP");

  AST_TIMEOUT: assert property (@(posedge clock) disable iff (rst)
    (ce && (c.ph != IDLE_S) && !scl_s && (c.tout_cnt == tout_last) && !start_ev && !stop_ev && !rise_ev)
    |=> (c.ph == IDLE_S) && !sda_oe)
    else $error("SCL low timeout did not reset");
endmodule
`default_nettype wire

/* File: src/tsee_consts.svh */
// Constants for the sensor and EEPROM two-wire slave
// Operation
// - Sample SDA on SCL rise, drive after fall
// - Reset release: conversion mode, EEPROM standby
// - Respond only when straps match address bits
// - Preamble 0011 sensor, 1010 EEPROM, then straps
// - Address LSB one reads, zero writes
// - Acknowledge matching address and written bytes
// - Master acks reads; NACK ends our drive
// - START is SDA fall with SCL high
// - STOP is SDA rise, ends transaction
// - Zero pulls SDA low, one releases
// - Write: address, pointer, then data bytes
// - STOP commits sensor write or starts programming
// - EEPROM is 16 pages of 16 bytes
// - Page write wraps low four address bits
// - Programming starts at STOP, uses latest buffer
// - No address acknowledge while programming runs
// - Delivery: protect flags clear, bytes 0xFF
// - Power-up clears both pointers to zero
// - Read sends from current selected pointer
// - Dummy write loads pointer without data
// - EEPROM read increments address, wraps around
// - SCL low timeout resets interface, frees SDA
`ifndef TSEE_CONSTS_SVH
`define TSEE_CONSTS_SVH
`define PRE_TS 4'h3
`define PRE_EE 4'hA
`define CNT_ZERO 4'h0
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define NB_PTR 2'h0
`define NB_D0 2'h1
`define NB_D1 2'h2
`define NB_MAX 2'h3
`define ERASED 8'hFF
`define PTR_RESET 8'h00
`define WP_RESET 2'h0
`define EE_BYTES 256
`define PAGE_BYTES 16
`define CLK_MHZ 100
`define TOUT_MS 25
`define WR_MS 5
`define TOUT_CYC (`TOUT_MS * 1000 * `CLK_MHZ)
`define WR_CYC (`WR_MS * 1000 * `CLK_MHZ)
`define TOUT_W 22
`define WR_W 19
`endif

/* File: src/tsee_pkg.sv */
// Types shared by the two-wire slave modules
`include "tsee_consts.svh"
package tsee_pkg;
  typedef enum logic [2:0] {
    IDLE_S = 3'b000,
    ADDR_S = 3'b001,
    ACKA_S = 3'b010,
    RX_S = 3'b011,
    ACKR_S = 3'b100,
    TX_S = 3'b101,
    TXACK_S = 3'b110,
    IGNORE_S = 3'b111
  } phase_t;

  typedef struct packed {
    logic [7:0] shift;
    logic tog;
  } link_rise_t;

  typedef struct packed {
    phase_t ph;
    logic [3:0] cnt;
    logic [1:0] nbyte;
    logic sel_presence_eeprom;
    logic rd;
    logic [7:0] tx;
    logic tx_lo;
    logic drive_req;
    logic scl_prev;
    logic sda_prev;
    logic tog_prev;
    logic [7:0] ts_ptr;
    logic [15:0] ts_wdata;
    logic ts_wr_valid;
    logic [7:0] ee_addr;
    logic [`PAGE_BYTES-1:0][7:0] page_buf;
    logic [`PAGE_BYTES-1:0] mask;
    logic [3:0] prog_page;
    logic busy;
    logic [`WR_W-1:0] wr_cnt;
    logic [`TOUT_W-1:0] tout_cnt;
    logic powered;
    logic [1:0] wp;
    logic [`EE_BYTES-1:0][7:0] mem;
  } core_t;
endpackage

/* File: src/link_if.sv */
// Signals between the SCL-clocked shifter and the core
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  logic [7:0] rx_byte;
  logic rx_tog;
  logic drive_req;
  logic drive_q;
  modport link (output rx_byte, output rx_tog, input drive_req, output drive_q);
  modport core (input rx_byte, input rx_tog, output drive_req, input drive_q);
endinterface
`default_nettype wire

/* File: src/bit_sync.sv */
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;
  sync_t sync_reg, sync_next;

  // First stage feeds only the second
  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = d_in;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
    end else if (ce) begin
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg.stable;
endmodule
`default_nettype wire

/* File: src/scl_shifter.sv */
// SCL-domain bit shifter and SDA drive stage
`timescale 1ns/1ps
`default_nettype none
module scl_shifter (
  // Link clock and reset
  input wire logic scl_clk,
  input wire logic rst,
  // Resolved data line
  input wire logic sda_i,
  // Core side
  link_if.link lk
);
  import tsee_pkg::*;
  link_rise_t rise_reg, rise_next;
  logic drive_reg;

  // Shift on every rise; toggle tells the core a bit landed
  always_comb begin
    rise_next = rise_reg;
    rise_next.shift = {rise_reg.shift[6:0], sda_i};
    rise_next.tog = ~rise_reg.tog;
  end

  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      rise_reg <= '0;
    end else begin
      rise_reg <= rise_next;
    end
  end

  // Core holds drive_req steady across the fall, so one capture is safe
  always_ff @(negedge scl_clk or posedge rst) begin
    if (rst) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= lk.drive_req;
    end
  end

  assign lk.rx_byte = rise_reg.shift;
  assign lk.rx_tog = rise_reg.tog;
  assign lk.drive_q = drive_reg;
endmodule
`default_nettype wire

/* File: dv/bus_host.sv */
// Two-wire bus master model: drives SCL, pulls SDA low open-drain
`timescale 1ns/1ps
`default_nettype none
module bus_host (
  // Bus lines
  output var logic scl,
  output var logic pull,
  input wire logic sda
);
  // Bus idle at time zero, SCL stands high outside frames
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // One clock: data set mid-low, sampled mid-high
  task automatic bitx(input logic o, output logic i);
    pull = ~o;
    #40;
    scl = 1'b1;
    #40;
    i = sda;
    #40;
    scl = 1'b0;
    #40;
  endtask
  // START, also repeated START from a low SCL
  task automatic start();
    pull = 1'b0;
    #40;
    scl = 1'b1;
    #80;
    pull = 1'b1;
    #80;
    scl = 1'b0;
    #40;
  endtask
  // STOP, then bus free time before anything else
  task automatic stop();
    pull = 1'b1;
    #40;
    scl = 1'b1;
    #80;
    pull = 1'b0;
    #160;
  endtask
  // Write a byte MSB first, return the slave acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic i;
    for (int k = 7; k >= 0; k--) begin
      bitx(b[k], i);
    end
    bitx(1'b1, i);
    ack = ~i;
  endtask
  // Read a byte, then acknowledge or end with a not-acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic i;
    for (int k = 7; k >= 0; k--) begin
      bitx(1'b1, i);
      d[k] = i;
    end
    bitx(last, i);
  endtask
endmodule
`default_nettype wire

/* File: dv/tsee_slave_bench.sv */
// Self-checking bench for the sensor and EEPROM two-wire slave
`timescale 1ns/1ps
`default_nettype none
module tsee_slave_bench;
  localparam logic [2:0] STRAP = 3'b101;
  localparam logic [7:0] EW = {4'hA, STRAP, 1'b0};
  localparam logic [7:0] ER = {4'hA, STRAP, 1'b1};
  logic clock, rst, ce, scl, pull, sda, sda_o, sda_oe, conv_mode, ee_standby, ee_busy, ts_wr_valid, ack;
  logic [2:0] strap;
  logic [15:0] ts_rd_data, ts_wr_data;
  logic [7:0] ts_ptr;
  logic [1:0] write_protect_flags;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int commits = 0;
  // Wired-AND data line with pull-up
  assign sda = ~((sda_oe & ~sda_o) | pull);
  bus_host host (.scl(scl), .pull(pull), .sda(sda));
  tsee_slave #(.TOUT_CYC(200), .WR_CYC(1000)) DUT (
    .clock(clock), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
    .ts_rd_data(ts_rd_data), .ts_ptr(ts_ptr), .ts_wr_data(ts_wr_data), .ts_wr_valid(ts_wr_valid),
    .conv_mode(conv_mode), .ee_standby(ee_standby), .ee_busy(ee_busy),
    .write_protect_flags(write_protect_flags)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard, well above the whole sequence
  always @(posedge clock) begin
    cycles <= cycles + 1;
    // Count commit pulses; the host's bus free time outlasts the one-cycle pulse
    if (ts_wr_valid === 1'b1) begin
      commits <= commits + 1;
    end
    if (cycles == 60000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] b);
    host.wbyte(b, ack);
    check("byte ack", ack, 1);
  endtask
  task automatic rexp(input logic [7:0] exp, input logic last);
    logic [7:0] d;
    host.rbyte(last, d);
    check("read byte", d, exp);
  endtask
  // Pointer load without data, then repeated START into a read
  task automatic seek(input logic [7:0] a);
    host.start();
    xfer(EW);
    xfer(a);
    host.start();
    xfer(ER);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 1500 && ee_busy !== 1'b0; n++) begin
      @(posedge clock);
    end
    check("ee_busy end", ee_busy, 0);
  endtask
  task automatic t_reset();
    check("ts_ptr", ts_ptr, 0);
    check("conv_mode", conv_mode, 1);
    check("ee_standby", ee_standby, 1);
    check("wp flags", write_protect_flags, 0);
    check("sda_oe idle", sda_oe, 0);
    check("sda_o", sda_o, 0);
  endtask
  task automatic t_fresh_read();
    host.start();
    xfer(ER);
    rexp(8'hFF, 1'b0);
    rexp(8'hFF, 1'b1);
    host.stop();
    check("released after stop", sda_oe, 0);
  endtask
  task automatic t_mismatch();
    logic [7:0] bad [5] = '{{4'hA, STRAP ^ 3'b001, 1'b0}, {4'hA, STRAP ^ 3'b100, 1'b1},
      {4'h3, STRAP ^ 3'b010, 1'b0}, {4'h6, STRAP, 1'b0}, {4'hB, STRAP, 1'b0}};
    foreach (bad[i]) begin
      host.start();
      host.wbyte(bad[i], ack);
      check("foreign address", ack, 0);
      host.wbyte(8'h00, ack);
      check("ignored byte", ack, 0);
      host.stop();
    end
    // A valid address with no START before it
    host.wbyte(EW, ack);
    check("no start", ack, 0);
    host.stop();
  endtask
  task automatic t_page_write();
    host.start();
    xfer(EW);
    xfer(8'h3E);
    // Eighteen bytes: the two first slots are overwritten
    for (int k = 0; k < 18; k++) begin
      xfer(8'h40 + 8'(k));
    end
    host.stop();
    repeat (6) @(posedge clock);
    check("busy after stop", ee_busy, 1);
    check("standby while busy", ee_standby, 0);
    host.start();
    host.wbyte(ER, ack);
    check("poll while busy", ack, 0);
    host.stop();
    wait_idle();
    seek(8'h3E);
    rexp(8'h50, 1'b0);
    rexp(8'h51, 1'b0);
    rexp(8'hFF, 1'b1);
    host.stop();
    seek(8'h30);
    rexp(8'h42, 1'b0);
    rexp(8'h43, 1'b1);
    host.stop();
  endtask
  task automatic t_wrap();
    host.start();
    xfer(EW);
    xfer(8'h00);
    xfer(8'h5A);
    host.stop();
    wait_idle();
    seek(8'hFF);
    rexp(8'hFF, 1'b0);
    rexp(8'h5A, 1'b1);
    host.stop();
  endtask
  task automatic t_sensor();
    check("no early commit", commits, 0);
    host.start();
    xfer({4'h3, STRAP, 1'b0});
    xfer(8'h05);
    xfer(8'h12);
    xfer(8'h34);
    host.stop();
    repeat (4) @(posedge clock);
    check("commit pulse", commits, 1);
    check("pulse ended", ts_wr_valid, 0);
    check("ts_ptr", ts_ptr, 16'h0005);
    check("ts_wr_data", ts_wr_data, 16'h1234);
    host.start();
    xfer({4'h3, STRAP, 1'b1});
    rexp(8'hBE, 1'b0);
    rexp(8'hEF, 1'b1);
    host.stop();
  endtask
  task automatic t_timeout();
    logic i;
    host.start();
    for (int k = 7; k >= 0; k--) begin
      host.bitx(EW[k], i);
    end
    check("ack driven", sda_oe, 1);
    // SCL held low about 500 ns beyond the 2000 ns shortened limit
    #2500;
    check("released on timeout", sda_oe, 0);
    host.stop();
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    strap = STRAP;
    ts_rd_data = 16'hBEEF;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    t_reset();
    t_fresh_read();
    t_mismatch();
    t_page_write();
    t_wrap();
    t_sensor();
    t_timeout();
    results();
  end
endmodule
`default_nettype wire
